// ==== rtl/sss_defs.svh ====
// register offsets, field positions, reset values and timing counts of the scan scheduler
// assumes a 100 MHz core clock and a word-indexed register port
`ifndef SSS_DEFS_SVH
`define SSS_DEFS_SVH
`define SSS_REG_CTRL    4'h0
`define SSS_REG_START   4'h1
`define SSS_REG_IVL2    4'h2
`define SSS_REG_BUDGET  4'h5
`define SSS_REG_STAT    4'h6
`define SSS_REG_IRQ_ST  4'h7
`define SSS_REG_IRQ_MSK 4'h8
`define SSS_CTRL_WARM   0
`define SSS_CTRL_FSEL   1
`define SSS_CTRL_REP    2
`define SSS_CTRL_CONST  5
`define SSS_STAT_LAG    4
`define SSS_STAT_WARM   7
`define SSS_BUDGET_MIN  7'h01
`define SSS_BUDGET_MAX  7'h64
`define SSS_BUDGET_RST  7'h0A
`define SSS_CLK_NS      10
`define SSS_MS_NS       1000000
`define SSS_MS_CYC      (`SSS_MS_NS / `SSS_CLK_NS)
`endif

// ==== rtl/sss_pkg.sv ====
// types shared by the scan scheduler and its bench
// constants live in sss_defs.svh
package sss_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_INIT, ST_MAIN, ST_BG, ST_WAIT} sss_state_t;
  typedef struct packed {
    logic first_scan;
    logic scan_start;
    logic main_done;
    logic task_done;
  } sss_scan_ev_t;
endpackage : sss_pkg

// ==== rtl/sss_scheduler.sv ====
// background task scheduler of a controller scan loop: init task, warm-restart task,
// three general tasks with one-shot or cyclic activation, time budget and status flags
// assumes scan events are one-cycle pulses from logic on ref_clk_i
//
// Overview of operation
// - init task runs once in first scan, before main, unless warm restart replaces it
// - task two general when function select 0, warm-restart task when 1
// - warm-restart task replaces init task if enabled and power loss was short
// - warm restart at start-up skips initial load and user data clearing
// - repeat select 0 gives one-shot, 1 gives cyclic activation
// - one-shot task activates on off-to-on change of its start request
// - one-shot activation clears the start request
// - pending one-shot requests checked at main and background completion
// - one-shot priority: task two, then three, then four
// - cyclic task runs once per interval-count scans while request stays on
// - each cyclic activation begins in the first scan of its group
// - cyclic priority: task two, then three, then four
// - cyclic task unfinished within its group sets its lag flag
// - floating scan: general tasks run after main within 1 to 100 ms budget
// - budget expiry suspends the task, resumed after main next scan
// - constant scan: tasks run in idle time until next scan start
// - one busy flag per background task, readable by the user program
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "sss_defs.svh"
module sss_scheduler import sss_pkg::*; #(
  parameter int unsigned IW     = 16,
  parameter int unsigned MS_CYC = `SSS_MS_CYC
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  // register port
  input  wire logic [3:0]   addr_i,
  input  wire logic [15:0]  wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  output logic      [15:0]  rdata_o,
  // scan controller
  input  wire sss_scan_ev_t scan_ev_i,
  input  wire logic         short_loss_i,
  output logic      [3:0]   run_o,
  output logic              main_run_o,
  output logic              warm_restart_o,
  output logic              irq_o
);
  localparam int unsigned BW = $clog2(100 * MS_CYC + 1);

  initial begin
    if (IW < 1 || IW > 16 || MS_CYC < 1) begin
      $error("sss_scheduler: unsupported parameters");
    end
  end

  function automatic logic [1:0] pick3(input logic [2:0] v);
    pick3 = v[0] ? 2'h0 : (v[1] ? 2'h1 : 2'h2);
  endfunction : pick3

  sss_state_t        state;
  logic [1:0]        loss_sync;
  logic              warm_en;
  logic              fsel;
  logic [2:0]        rep;
  logic              const_mode;
  logic [2:0]        start;
  logic [2:0]        start_d;
  logic [2:0]        os_pend;
  logic [IW-1:0]     ivl [3];
  logic [IW-1:0]     cnt [3];
  logic [6:0]        budget_ms;
  logic [BW-1:0]     bud_cnt;
  logic [3:0]        act;
  logic [1:0]        cur;
  logic [2:0]        lag;
  logic [6:0]        irq_st;
  logic [6:0]        irq_msk;

  logic [2:0]        gen_en;
  logic [2:0]        oneshot;
  logic [2:0]        cyclic;
  logic [2:0]        due;
  logic [2:0]        lag_ev;
  logic              warm_cond;
  logic              check;
  logic              expire;
  logic [3:0]        done_clr;
  logic [3:0]        live;
  logic [2:0]        os_take;
  logic              pick_v;
  logic [1:0]        pick_idx;
  logic              wr_ctrl;
  logic              wr_start;

  assign wr_ctrl   = wr_i && addr_i == `SSS_REG_CTRL;
  assign wr_start  = wr_i && addr_i == `SSS_REG_START;
  assign gen_en    = {2'b11, ~fsel};
  assign oneshot   = gen_en & ~rep;
  assign cyclic    = gen_en & rep;
  assign warm_cond = warm_en && fsel && loss_sync[1];
  assign check     = (state == ST_MAIN && scan_ev_i.main_done)
                  || (state == ST_BG && scan_ev_i.task_done);
  assign expire    = state == ST_BG && !const_mode && bud_cnt == '0;

  // a group starts on a scan start with the counter at zero
  always_comb begin
    for (int g = 0; g < 3; g++) begin
      due[g]    = scan_ev_i.scan_start && cyclic[g] && start[g] && cnt[g] == '0;
      lag_ev[g] = due[g] && act[g+1];
    end
  end

  always_comb begin
    done_clr = '0;
    if ((state == ST_INIT || state == ST_BG) && scan_ev_i.task_done) begin
      done_clr[cur] = 1'b1;
    end
    live     = act & ~done_clr;
    os_take  = '0;
    pick_v   = 1'b0;
    pick_idx = 2'h0;
    if (check) begin
      if (|live[3:1]) begin
        // resume suspended or due work before taking new one-shot requests
        pick_v   = 1'b1;
        pick_idx = 2'(pick3(live[3:1]) + 2'h1);
      end else if (|os_pend) begin
        pick_v   = 1'b1;
        pick_idx = 2'(pick3(os_pend) + 2'h1);
        os_take[pick3(os_pend)] = 1'b1;
      end
    end
  end

  // the first stage only feeds the second
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      loss_sync <= 2'h0;
    end else begin
      loss_sync <= {loss_sync[0], short_loss_i};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      warm_en    <= 1'b0;
      fsel       <= 1'b0;
      rep        <= 3'h0;
      const_mode <= 1'b0;
      budget_ms  <= `SSS_BUDGET_RST;
      irq_msk    <= 7'h00;
    end else if (wr_i) begin
      if (addr_i == `SSS_REG_CTRL) begin
        warm_en    <= wdata_i[`SSS_CTRL_WARM];
        fsel       <= wdata_i[`SSS_CTRL_FSEL];
        rep        <= wdata_i[`SSS_CTRL_REP +: 3];
        const_mode <= wdata_i[`SSS_CTRL_CONST];
      end
      if (addr_i == `SSS_REG_BUDGET) begin
        // out-of-range budgets are clamped into 1..100 ms
        if (wdata_i[6:0] == 7'h00 && wdata_i[15:7] == '0) begin
          budget_ms <= `SSS_BUDGET_MIN;
        end else if (wdata_i > 16'(`SSS_BUDGET_MAX)) begin
          budget_ms <= `SSS_BUDGET_MAX;
        end else begin
          budget_ms <= wdata_i[6:0];
        end
      end
      if (addr_i == `SSS_REG_IRQ_MSK) begin
        irq_msk <= wdata_i[6:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int g = 0; g < 3; g++) begin
        ivl[g] <= '0;
      end
    end else begin
      for (int g = 0; g < 3; g++) begin
        if (wr_i && addr_i == 4'(`SSS_REG_IVL2 + g)) begin
          ivl[g] <= wdata_i[IW-1:0];
        end
      end
    end
  end

  // a software write wins over the device clear of the same cycle
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start   <= 3'h0;
      start_d <= 3'h0;
    end else begin
      start_d <= start;
      if (wr_start) begin
        start <= wdata_i[2:0];
      end else begin
        start <= start & ~os_take;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      os_pend <= 3'h0;
    end else begin
      os_pend <= (os_pend & ~os_take & oneshot) | (start & ~start_d & oneshot);
    end
  end

  // an interval of zero or one runs the task every scan
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int g = 0; g < 3; g++) begin
        cnt[g] <= '0;
      end
    end else begin
      for (int g = 0; g < 3; g++) begin
        if (!(cyclic[g] && start[g])) begin
          cnt[g] <= '0;
        end else if (scan_ev_i.scan_start) begin
          if (cnt[g] != '0) begin
            cnt[g] <= cnt[g] - 1'b1;
          end else if (ivl[g] > 1) begin
            cnt[g] <= ivl[g] - 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act <= 4'h0;
    end else begin
      act <= live | {due & ~act[3:1], 1'b0} | {os_take, 1'b0};
      if (state == ST_IDLE && scan_ev_i.first_scan) begin
        act[{1'b0, warm_cond}] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bud_cnt <= '0;
    end else if (state == ST_MAIN && scan_ev_i.main_done) begin
      bud_cnt <= BW'(budget_ms * MS_CYC - 1);
    end else if (state == ST_BG && bud_cnt != '0) begin
      bud_cnt <= bud_cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state          <= ST_IDLE;
      cur            <= 2'h0;
      run_o          <= 4'h0;
      main_run_o     <= 1'b0;
      warm_restart_o <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (scan_ev_i.first_scan) begin
            state          <= ST_INIT;
            cur            <= {1'b0, warm_cond};
            run_o          <= warm_cond ? 4'h2 : 4'h1;
            warm_restart_o <= warm_cond;
          end
        end
        ST_INIT: begin
          if (scan_ev_i.task_done) begin
            state      <= ST_MAIN;
            run_o      <= 4'h0;
            main_run_o <= 1'b1;
          end
        end
        ST_MAIN: begin
          if (scan_ev_i.main_done) begin
            main_run_o <= 1'b0;
            state      <= pick_v ? ST_BG : ST_WAIT;
            cur        <= pick_idx;
            run_o      <= pick_v ? 4'h1 << pick_idx : 4'h0;
          end
        end
        ST_BG: begin
          if (scan_ev_i.scan_start) begin
            state      <= ST_MAIN;
            run_o      <= 4'h0;
            main_run_o <= 1'b1;
          end else if (scan_ev_i.task_done) begin
            state <= pick_v ? ST_BG : ST_WAIT;
            cur   <= pick_idx;
            run_o <= pick_v ? 4'h1 << pick_idx : 4'h0;
          end else if (expire) begin
            state <= ST_WAIT;
            run_o <= 4'h0;
          end
        end
        ST_WAIT: begin
          if (scan_ev_i.scan_start) begin
            state      <= ST_MAIN;
            main_run_o <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          run_o <= 4'h0;
        end
      endcase
    end
  end

  // lag and event flags: hardware set wins over a write-one clear
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lag    <= 3'h0;
      irq_st <= 7'h00;
      irq_o  <= 1'b0;
    end else begin
      lag <= (lag & ~((wr_i && addr_i == `SSS_REG_STAT) ? wdata_i[6:4] : 3'h0))
           | lag_ev;
      irq_st <= (irq_st & ~((wr_i && addr_i == `SSS_REG_IRQ_ST) ? wdata_i[6:0] : 7'h00))
              | {lag_ev, done_clr};
      irq_o  <= |(irq_st & irq_msk);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `SSS_REG_CTRL:    rdata_o <= {10'h000, const_mode, rep, fsel, warm_en};
        `SSS_REG_START:   rdata_o <= {13'h0000, start};
        `SSS_REG_BUDGET:  rdata_o <= {9'h000, budget_ms};
        `SSS_REG_STAT:    rdata_o <= {8'h00, warm_restart_o, lag, act};
        `SSS_REG_IRQ_ST:  rdata_o <= {9'h000, irq_st};
        `SSS_REG_IRQ_MSK: rdata_o <= {9'h000, irq_msk};
        default: begin
          if (addr_i >= `SSS_REG_IVL2 && addr_i < `SSS_REG_BUDGET) begin
            rdata_o <= 16'(ivl[2'(addr_i - `SSS_REG_IVL2)]);
          end else begin
            rdata_o <= 16'h0000;
          end
        end
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  sequence s_first;
    state == ST_IDLE && scan_ev_i.first_scan;
  endsequence
  sequence s_warm;
    s_first and warm_cond;
  endsequence

  property p_init_first;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    s_first and !warm_cond |=> run_o == 4'h1 && !main_run_o && act[0];
  endproperty
  a_init_first: assert property (p_init_first) else $error("init task not run");

  property p_warm_replace;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    s_warm |=> run_o == 4'h2 && !act[0] ##1 warm_restart_o;
  endproperty
  a_warm_replace: assert property (p_warm_replace) else $error("warm task wrong");

  property p_fsel_excl;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    fsel && $past(fsel) && state == ST_MAIN |-> !os_pend[0] && !due[0];
  endproperty
  a_fsel_excl: assert property (p_fsel_excl) else $error("task two ran as general");

  property p_os_clear;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    os_take[1] && !wr_start |=> !start[1] && act[2] ##1 !start[1] || start_d[1];
  endproperty
  a_os_clear: assert property (p_os_clear) else $error("start flag kept");

  property p_prio;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    check && !scan_ev_i.scan_start && !live[1] && live[2] && live[3]
      |=> run_o[2] && !run_o[3];
  endproperty
  a_prio: assert property (p_prio) else $error("priority violated");

  property p_lag;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    due[0] && act[1] |=> lag[0] && irq_st[4];
  endproperty
  a_lag: assert property (p_lag) else $error("lag not flagged");

  property p_budget;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    expire && !scan_ev_i.scan_start && !scan_ev_i.task_done
      |=> run_o == 4'h0 && state == ST_WAIT && act == $past(act);
  endproperty
  a_budget: assert property (p_budget) else $error("budget not enforced");

  property p_const;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    state == ST_BG && const_mode && !scan_ev_i.task_done
      |=> $past(scan_ev_i.scan_start) ? (run_o == 4'h0 && main_run_o) : state == ST_BG;
  endproperty
  a_const: assert property (p_const) else $error("idle run not stopped");

  property p_busy;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    run_o != 4'h0 |-> $onehot(run_o) && (run_o & ~act) == 4'h0;
  endproperty
  a_busy: assert property (p_busy) else $error("running task not busy");

  property p_cyc_start;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    due[0] && !act[1] |=> act[1] && cnt[0] == (ivl[0] > 1 ? ivl[0] - 1'b1 : '0);
  endproperty
  a_cyc_start: assert property (p_cyc_start) else $error("cyclic start missed");

endmodule : sss_scheduler
`default_nettype wire

// ==== test/sss_scan_model.sv ====
// scan controller and task timing model facing the scan scheduler
// assumes the bench asks for scan starts and sets how long a background task takes
`timescale 1ns/100ps
`default_nettype none
module sss_scan_model import sss_pkg::*; (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  // bench requests
  input  wire logic         first_req_i,
  input  wire logic         scan_req_i,
  input  wire logic [7:0]   task_len_i,
  // scheduler grants
  input  wire logic [3:0]   run_i,
  input  wire logic         main_run_i,
  output var  sss_scan_ev_t scan_ev_o
);
  logic [7:0] tcnt;
  logic [7:0] mcnt;
  logic [3:0] run_q;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scan_ev_o <= '0;
      tcnt      <= 8'h00;
      mcnt      <= 8'h00;
      run_q     <= 4'h0;
    end else begin
      run_q                <= run_i;
      scan_ev_o.first_scan <= first_req_i;
      scan_ev_o.scan_start <= scan_req_i;
      // main task always takes three cycles
      scan_ev_o.main_done  <= main_run_i && mcnt == 8'h02 && !scan_ev_o.main_done;
      mcnt                 <= (main_run_i && !scan_ev_o.main_done) ? mcnt + 8'h01 : 8'h00;
      // progress is lost when a task is cut off: slower than a real one, never faster
      if (run_i == 4'h0 || run_i != run_q || scan_ev_o.task_done) begin
        tcnt <= 8'h00;
      end else begin
        tcnt <= tcnt + 8'h01;
      end
      scan_ev_o.task_done  <= run_i != 4'h0 && run_i == run_q && tcnt == task_len_i
                              && !scan_ev_o.task_done;
    end
  end
endmodule : sss_scan_model
`default_nettype wire

// ==== test/sss_scheduler_tb.sv ====
// self-checking bench of the scan scheduler
// assumes sss_scan_model plays the scan controller; registers reached over the plain port
`timescale 1ns/100ps
`default_nettype none
module sss_scheduler_tb import sss_pkg::*;;
  logic         ref_clk_i;
  logic         rstn_i;
  logic [3:0]   addr_i;
  logic [15:0]  wdata_i;
  logic         wr_i;
  logic         rd_i;
  logic         short_loss_i;
  logic         first_req;
  logic         scan_req;
  logic [7:0]   task_len;
  wire  logic [15:0] rdata_o;
  wire  logic [3:0]  run_o;
  wire  logic        main_run_o;
  wire  logic        warm_restart_o;
  wire  logic        irq_o;
  sss_scan_ev_t scan_ev;
  int           mismatches;
  int           check_count;
  int           act;
  int           seed;
  logic         two_q;
  logic [2:0]   r;

  sss_scheduler #(.MS_CYC(10)) sss_scheduler_i (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scan_ev_i(scan_ev),
    .short_loss_i(short_loss_i), .run_o(run_o), .main_run_o(main_run_o),
    .warm_restart_o(warm_restart_o), .irq_o(irq_o));
  sss_scan_model sss_scan_model_i (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .first_req_i(first_req),
    .scan_req_i(scan_req), .task_len_i(task_len), .run_i(run_o),
    .main_run_i(main_run_o), .scan_ev_o(scan_ev));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  always @(negedge ref_clk_i) begin
    if (run_o[1] === 1'b1 && two_q !== 1'b1) act++;
    two_q = run_o[1];
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (exp !== got) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e,
                        input string nm);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(nm, e, rdata_o & m);
  endtask : rd_reg

  task automatic pulse(input logic first);
    @(posedge ref_clk_i);
    if (first) first_req <= 1'b1;
    else scan_req <= 1'b1;
    @(posedge ref_clk_i);
    first_req <= 1'b0;
    scan_req  <= 1'b0;
  endtask : pulse

  task automatic wait_run(input logic [3:0] e, input string nm);
    for (int i = 0; i < 80 && run_o !== e; i++) @(negedge ref_clk_i);
    chk(nm, {12'h000, e}, {12'h000, run_o});
  endtask : wait_run

  task automatic scans(input int n);
    repeat (n) begin
      pulse(1'b0);
      repeat (40) @(posedge ref_clk_i);
    end
  endtask : scans

  // one-shot grant expected first among pending requests
  function automatic logic [3:0] first_of(input logic [2:0] q);
    return q[0] ? 4'h2 : q[1] ? 4'h4 : 4'h8;
  endfunction : first_of

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  initial begin
    seed = 95;
    {rstn_i, wr_i, rd_i, first_req, scan_req, short_loss_i} = '0;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    task_len = 8'h14;
    repeat (4) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd_reg(4'h6, 16'hFFFF, 16'h0000, "status_rst");
    rd_reg(4'h5, 16'hFFFF, 16'h000A, "budget_rst");
    wr_reg(4'h9, 16'hFFFF);
    rd_reg(4'h9, 16'hFFFF, 16'h0000, "unmapped");
    wr_reg(4'h5, 16'h0000);
    rd_reg(4'h5, 16'hFFFF, 16'h0001, "budget_min");
    wr_reg(4'h5, 16'h00C8);
    rd_reg(4'h5, 16'hFFFF, 16'h0064, "budget_max");
    wr_reg(4'h5, 16'h0002);
    pulse(1'b1);
    wait_run(4'h1, "init_run");
    chk("main_held", 16'h0000, {15'h0, main_run_o});
    rd_reg(4'h6, 16'h000F, 16'h0001, "init_busy");
    wait_run(4'h0, "init_done");
    chk("cold_start", 16'h0000, {15'h0, warm_restart_o});
    chk("main_after_init", 16'h0001, {15'h0, main_run_o});
    // let the first main task finish so the first request waits for a scan
    repeat (6) @(posedge ref_clk_i);
    $display("test first_scan done");
    task_len <= 8'h03;
    for (int n = 0; n < 4; n++) begin
      r = 3'($random(seed));
      if (r == 3'h0) r = 3'h5;
      wr_reg(4'h1, {13'h0000, r});
      chk("no_grant_before_main", 16'h0000, {12'h000, run_o});
      pulse(1'b0);
      for (int b = 0; b < 3; b++) begin
        if (r != 3'h0) wait_run(first_of(r), "oneshot_order");
        r = r & ~3'(first_of(r) >> 1);
      end
      wait_run(4'h0, "oneshot_end");
      rd_reg(4'h1, 16'h0007, 16'h0000, "start_cleared");
    end
    $display("test oneshot done");
    task_len <= 8'hC8;
    wr_reg(4'h1, 16'h0002);
    pulse(1'b0);
    wait_run(4'h4, "three_run");
    wait_run(4'h0, "three_cut");
    rd_reg(4'h6, 16'h0004, 16'h0004, "busy_held");
    task_len <= 8'h03;
    pulse(1'b0);
    wait_run(4'h4, "three_resume");
    wait_run(4'h0, "three_end");
    rd_reg(4'h6, 16'h0004, 16'h0000, "busy_off");
    $display("test budget done");
    wr_reg(4'h0, 16'h0004);
    wr_reg(4'h2, 16'h0003);
    wr_reg(4'h1, 16'h0001);
    act = 0;
    scans(9);
    chk("cyclic_count", 16'h0003, 16'(act));
    task_len <= 8'hFF;
    wr_reg(4'h2, 16'h0001);
    wr_reg(4'h8, 16'h0010);
    scans(3);
    rd_reg(4'h6, 16'h0010, 16'h0010, "lag_two");
    chk("irq_on", 16'h0001, {15'h0, irq_o});
    wr_reg(4'h1, 16'h0000);
    wr_reg(4'h8, 16'h0000);
    repeat (2) @(negedge ref_clk_i);
    chk("irq_masked", 16'h0000, {15'h0, irq_o});
    task_len <= 8'h03;
    scans(1);
    wr_reg(4'h7, 16'h0010);
    rd_reg(4'h7, 16'h0010, 16'h0000, "irq_cleared");
    $display("test cyclic done");
    task_len <= 8'hFF;
    wr_reg(4'h0, 16'h0020);
    wr_reg(4'h1, 16'h0004);
    pulse(1'b0);
    wait_run(4'h8, "four_run");
    repeat (30) @(negedge ref_clk_i);
    chk("four_idle_time", 16'h0008, {12'h000, run_o});
    pulse(1'b0);
    wait_run(4'h0, "four_scan_cut");
    $display("test constant done");
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    short_loss_i <= 1'b1;
    task_len <= 8'h03;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    wr_reg(4'h0, 16'h0003);
    repeat (3) @(posedge ref_clk_i);
    pulse(1'b1);
    wait_run(4'h2, "warm_task");
    chk("warm_flag", 16'h0001, {15'h0, warm_restart_o});
    rd_reg(4'h6, 16'h0081, 16'h0080, "warm_status");
    wait_run(4'h0, "warm_done");
    chk("main_after_warm", 16'h0001, {15'h0, main_run_o});
    // task two is the warm-restart task now, so a start request must not run it
    wr_reg(4'h1, 16'h0001);
    pulse(1'b0);
    repeat (20) @(negedge ref_clk_i);
    chk("warm_no_general", 16'h0000, {12'h000, run_o});
    $display("test warm done");
    print_verdict();
  end
endmodule : sss_scheduler_tb
`default_nettype wire
